// ===== hw/stat_consts.svh
`ifndef STAT_CONSTS_SVH
`define STAT_CONSTS_SVH

// ----------------------------------------
// register addresses (word index)
// ----------------------------------------
`define ADDR_IDLE_ERR 8'h09
`define ADDR_TX_HIGH 8'h0a
`define ADDR_TX_MID 8'h0b
`define ADDR_TX_LOW 8'h0c
`define ADDR_CTRL 8'h10

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define CTRL_ERR_EN_BIT 0
`define CTRL_TX_EN_BIT 1
`define CTRL_RESET 2'h3
`define COUNT16_RESET 16'h0000
`define COUNT48_RESET 48'h0000_0000_0000
`define RDATA_UNMAPPED 16'h0000

`endif

// ===== hw/stat_pkg.sv
package stat_pkg;
	typedef logic [15:0] word_t;
	typedef logic [47:0] count48_t;

	typedef struct packed {
		logic line_meta;
		logic line_sync;
		logic phase;
		logic valid_hold;
		logic error_prev;
		word_t idle_err_cnt;
		count48_t tx_cnt;
		word_t snap_mid;
		word_t snap_high;
		logic [1:0] ctrl;
		word_t rdata;
	} stat_state_s;
endpackage

// ===== hw/phy_stat_counters.sv
`timescale 1ns/100ps
`include "stat_consts.svh"
// Operation
// R1 - count receive error rising edges while receive valid is low, 16 bits
// R2 - idle error count read returns value, then clears; zero after reset
// R3 - error and valid flags come from the one receive control line
// R4 - 48-bit sent frame count seen as high, mid, low 16-bit words
// R5 - each transmitted packet adds one; all 48 bits zero after reset
// R6 - reading the high word clears the whole 48-bit count
// R7 - software reads low, then mid, then high for a correct value
// R8 - reading mid or low words leaves the count unchanged
// R9 - low word read captures mid and high for a coherent value
module phy_stat_counters
	import stat_pkg::*;
(
	input wire logic mclk, // core clock, 25 MHz
	input wire logic rst_n, // async reset, active low
	input wire logic [7:0] addr, // register address
	input wire logic [15:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [15:0] rdata, // read data, cycle after rd
	input wire logic receive_control_line, // receive control pin, two samples per symbol
	input wire logic tx_packet_done // one pulse per transmitted packet
);

	stat_state_s st_reg;
	stat_state_s st_next;

	logic rd_idle;
	logic rd_high;
	logic rd_mid;
	logic rd_low;
	logic receive_valid_flag;
	logic receive_error_flag;
	logic err_evt;
	logic tx_evt;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
		return a == target;
	endfunction

	// a clear and an event together leave one count, never zero
	function automatic word_t bump16(input word_t cnt, input logic cleared);
		return cleared ? 16'h0001 : 16'(cnt + 16'h0001);
	endfunction

	function automatic count48_t bump48(input count48_t cnt, input logic cleared);
		return cleared ? 48'h0000_0000_0001 : 48'(cnt + 48'h0000_0000_0001);
	endfunction

	// ----------------------------------------
	// decode and events
	// ----------------------------------------
	always_comb begin
		rd_idle = rd && hit(addr, `ADDR_IDLE_ERR);
		rd_high = rd && hit(addr, `ADDR_TX_HIGH);
		rd_mid = rd && hit(addr, `ADDR_TX_MID);
		rd_low = rd && hit(addr, `ADDR_TX_LOW);
		// first half carries valid, second half valid xor error
		receive_valid_flag = st_reg.valid_hold; // R3
		receive_error_flag = st_reg.valid_hold ^ st_reg.line_sync; // R3
		err_evt = st_reg.phase && receive_error_flag && !st_reg.error_prev && !receive_valid_flag
			&& st_reg.ctrl[`CTRL_ERR_EN_BIT]; // R1
		tx_evt = tx_packet_done && st_reg.ctrl[`CTRL_TX_EN_BIT];
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.line_meta = receive_control_line;
		st_next.line_sync = st_reg.line_meta;
		st_next.phase = !st_reg.phase;
		if (!st_reg.phase) begin
			st_next.valid_hold = st_reg.line_sync; // R3
		end else begin
			st_next.error_prev = receive_error_flag;
		end
		// set wins over the read clear, so no event is lost
		if (rd_idle) begin
			st_next.idle_err_cnt = `COUNT16_RESET; // R2
		end
		if (err_evt) begin
			st_next.idle_err_cnt = bump16(st_reg.idle_err_cnt, rd_idle); // R1
		end
		if (rd_high) begin
			st_next.tx_cnt = `COUNT48_RESET; // R6
		end
		if (tx_evt) begin
			st_next.tx_cnt = bump48(st_reg.tx_cnt, rd_high); // R5
		end
		if (rd_low) begin
			st_next.snap_mid = st_reg.tx_cnt[31:16]; // R9
			st_next.snap_high = st_reg.tx_cnt[47:32]; // R9
		end
		if (wr && hit(addr, `ADDR_CTRL)) begin
			st_next.ctrl = wdata[1:0];
		end
		st_next.rdata = `RDATA_UNMAPPED;
		if (rd) begin
			unique case (1'b1)
				rd_idle: st_next.rdata = st_reg.idle_err_cnt; // R2
				rd_high: st_next.rdata = st_reg.snap_high; // R4
				rd_mid: st_next.rdata = st_reg.snap_mid; // R4
				rd_low: st_next.rdata = st_reg.tx_cnt[15:0]; // R4
				hit(addr, `ADDR_CTRL): st_next.rdata = {14'h0000, st_reg.ctrl};
				default: st_next.rdata = `RDATA_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '{
				line_meta: 1'b0,
				line_sync: 1'b0,
				phase: 1'b0,
				valid_hold: 1'b0,
				error_prev: 1'b0,
				idle_err_cnt: `COUNT16_RESET,
				tx_cnt: `COUNT48_RESET,
				snap_mid: `COUNT16_RESET,
				snap_high: `COUNT16_RESET,
				ctrl: `CTRL_RESET,
				rdata: `RDATA_UNMAPPED
			};
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata = st_reg.rdata;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence low_read_s;
		rd_low && !tx_evt;
	endsequence

	sequence mid_read_s;
		rd_mid;
	endsequence

	sequence high_read_s;
		rd_high;
	endsequence

	idle_count_a: assert property (err_evt && !rd_idle |=> // R1
		st_reg.idle_err_cnt == 16'($past(st_reg.idle_err_cnt) + 16'h0001))
		else $error("idle error count did not advance");
	idle_clear_a: assert property (rd_idle && !err_evt |=> // R2
		st_reg.idle_err_cnt == 16'h0000 && rdata == $past(st_reg.idle_err_cnt))
		else $error("idle error read did not return and clear");
	line_decode_a: assert property (st_reg.phase && !$past(st_reg.phase) |-> // R3
		receive_error_flag == ($past(st_reg.line_sync) ^ st_reg.line_sync))
		else $error("error flag not decoded from control line");
	low_word_a: assert property (rd_low |=> rdata == $past(st_reg.tx_cnt[15:0])) // R4
		else $error("low word read wrong");
	tx_count_a: assert property (tx_evt && !rd_high |=> // R5
		st_reg.tx_cnt == 48'($past(st_reg.tx_cnt) + 48'h1))
		else $error("sent frame count did not advance");
	high_clear_a: assert property (rd_high && !tx_evt |=> st_reg.tx_cnt == 48'h0) // R6
		else $error("high read did not clear count");
	mid_keep_a: assert property ((rd_mid || rd_low) && !tx_evt |=> // R8
		st_reg.tx_cnt == $past(st_reg.tx_cnt))
		else $error("mid or low read changed count");
	snap_mid_a: assert property (low_read_s ##1 mid_read_s |=> // R9
		rdata == $past(st_reg.tx_cnt[31:16], 2))
		else $error("mid word not coherent with low read");

	// ----------------------------------------
	// decode, hold, snapshot, clear and bus checks
	// ----------------------------------------
	// halves must alternate or valid and error swap places
	phase_toggle_a: assert property (1'b1 |=> // R3
		st_reg.phase != $past(st_reg.phase))
		else $error("decode phase did not alternate");
	valid_capture_a: assert property (!st_reg.phase |=> // R3
		st_reg.valid_hold == $past(st_reg.line_sync))
		else $error("receive valid not taken from first half");

	// a stray step here means a lost or doubled edge
	idle_hold_a: assert property (!err_evt && !rd_idle |=> // R1
		$stable(st_reg.idle_err_cnt))
		else $error("idle error count moved without event");
	idle_set_wins_a: assert property (err_evt && rd_idle |=> // R2
		st_reg.idle_err_cnt == 16'h0001)
		else $error("idle error event lost against read clear");
	tx_hold_a: assert property (!tx_evt && !rd_high |=> // R8
		$stable(st_reg.tx_cnt))
		else $error("sent frame count moved without packet");
	tx_set_wins_a: assert property (tx_evt && rd_high |=> // R6
		st_reg.tx_cnt == 48'h0000_0000_0001)
		else $error("packet lost against high read clear");

	// upper words frozen at the low read, so a carry between reads cannot tear the value
	snap_take_a: assert property (rd_low |=> // R9
		st_reg.snap_mid == $past(st_reg.tx_cnt[31:16]) && st_reg.snap_high == $past(st_reg.tx_cnt[47:32]))
		else $error("low read did not capture upper words");
	snap_keep_a: assert property (!rd_low |=> // R9
		$stable(st_reg.snap_mid) && $stable(st_reg.snap_high))
		else $error("snapshot changed without low read");
	snap_high_a: assert property (low_read_s ##1 mid_read_s ##1 high_read_s |=> // R9
		rdata == $past(st_reg.tx_cnt[47:32], 3))
		else $error("high word not coherent with low read");

	// read data falls back to zero so a stale word is never taken twice
	rdata_idle_a: assert property (!rd |=> rdata == `RDATA_UNMAPPED)
		else $error("read data stood longer than one cycle");
	unmapped_read_a: assert property (rd && !rd_idle && !rd_high && !rd_mid && !rd_low
		&& !hit(addr, `ADDR_CTRL) |=> rdata == `RDATA_UNMAPPED)
		else $error("unmapped read returned data");
	ctrl_write_a: assert property (wr && hit(addr, `ADDR_CTRL) |=> st_reg.ctrl == $past(wdata[1:0]))
		else $error("control write not taken");

endmodule

// ===== tb/mac_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// far-side mac: receive symbols and tx pulses
// ----------------------------------------
module mac_model (
	input wire logic mclk, // core clock
	input wire logic rst_n, // async reset, active low
	input wire logic sym_valid, // wanted receive valid
	input wire logic sym_error, // wanted receive error
	input wire logic pkt_req, // one packet per high cycle
	output logic receive_control_line, // encoded receive control pin
	output logic tx_packet_done // packet pulse
);
	logic half_reg;
	logic err_reg;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			half_reg <= 1'b0;
			err_reg <= 1'b0;
			receive_control_line <= 1'b0;
			tx_packet_done <= 1'b0;
		end else begin
			half_reg <= ~half_reg;
			tx_packet_done <= pkt_req;
			// symbol latched on the valid half so a mid-symbol change cannot mix halves
			if (half_reg) begin
				receive_control_line <= sym_valid;
				err_reg <= sym_valid ^ sym_error;
			end else begin
				receive_control_line <= err_reg;
			end
		end
	end
endmodule

// ===== tb/phy_stat_counters_tb.sv
`timescale 1ns/100ps
`include "stat_consts.svh"
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
	$display("MISMATCH %s exp %h got %h", n, e, a); end end
module phy_stat_counters_tb;
	import stat_pkg::*;
	logic mclk = 0, rst_n = 0, wr = 0, rd = 0, sv = 0, se = 0, pk = 0;
	logic [7:0] addr = 8'h00;
	word_t wdata = 16'h0000;
	word_t rdata;
	logic rcl, txd;
	int miscompares = 0, n_tests = 0;
	phy_stat_counters u_phy_stat_counters (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .receive_control_line(rcl), .tx_packet_done(txd));
	mac_model u_mac_model (.mclk(mclk), .rst_n(rst_n), .sym_valid(sv), .sym_error(se), .pkt_req(pk),
		.receive_control_line(rcl), .tx_packet_done(txd));
	initial forever #20 mclk = ~mclk;
	// ----------------------------------------
	// bus and scenario tasks
	// ----------------------------------------
	task automatic rd_chk(input logic [7:0] a, input word_t e, input string n);
		@(posedge mclk) begin rd <= 1'b1; addr <= a; end
		@(posedge mclk) rd <= 1'b0;
		#1 `CHK(n, e, rdata)
	endtask
	task automatic wr_reg(input logic [7:0] a, input word_t d);
		@(posedge mclk) begin wr <= 1'b1; addr <= a; wdata <= d; end
		@(posedge mclk) wr <= 1'b0;
	endtask
	task automatic sym(input logic v, input logic e);
		@(posedge mclk) begin sv <= v; se <= e; end
		repeat (3) @(posedge mclk);
	endtask
	task automatic t_reset();
		rd_chk(`ADDR_IDLE_ERR, `COUNT16_RESET, "idle reset");
		rd_chk(`ADDR_TX_LOW, `COUNT16_RESET, "low reset");
		rd_chk(`ADDR_TX_MID, `COUNT16_RESET, "mid reset");
		rd_chk(`ADDR_TX_HIGH, `COUNT16_RESET, "high reset");
		rd_chk(8'h00, `RDATA_UNMAPPED, "unmapped");
		$display("test reset done");
	endtask
	task automatic t_tx();
		wr_reg(`ADDR_CTRL, 16'h0003);
		pk <= 1'b1;
		repeat (3) @(posedge mclk);
		pk <= 1'b0;
		repeat (3) @(posedge mclk);
		rd_chk(`ADDR_TX_MID, 16'h0000, "mid first");
		rd_chk(`ADDR_TX_LOW, 16'h0003, "low");
		rd_chk(`ADDR_TX_MID, 16'h0000, "mid");
		rd_chk(`ADDR_TX_HIGH, 16'h0000, "high");
		rd_chk(`ADDR_TX_LOW, 16'h0000, "low cleared");
		$display("test tx count done");
	endtask
	task automatic t_burst();
		@(posedge mclk) pk <= 1'b1;
		repeat (5) @(posedge mclk);
		pk <= 1'b0;
		repeat (3) @(posedge mclk);
		rd_chk(`ADDR_TX_LOW, 16'h0005, "low keep 1");
		rd_chk(`ADDR_TX_LOW, 16'h0005, "low keep 2");
		@(posedge mclk) begin rd <= 1'b1; addr <= `ADDR_TX_LOW; end
		@(posedge mclk) addr <= `ADDR_TX_MID;
		#1 `CHK("burst low", 16'h0005, rdata)
		@(posedge mclk) addr <= `ADDR_TX_HIGH;
		#1 `CHK("burst mid", 16'h0000, rdata)
		@(posedge mclk) rd <= 1'b0;
		#1 `CHK("burst high", 16'h0000, rdata)
		rd_chk(`ADDR_TX_LOW, 16'h0000, "burst cleared");
		$display("test burst read done");
	endtask
	task automatic t_ctrl();
		wr_reg(`ADDR_CTRL, 16'h0000);
		rd_chk(`ADDR_CTRL, 16'h0000, "ctrl off");
		@(posedge mclk) pk <= 1'b1;
		repeat (2) @(posedge mclk);
		pk <= 1'b0;
		sym(0, 0);
		sym(0, 1);
		sym(0, 0);
		repeat (8) @(posedge mclk);
		rd_chk(`ADDR_TX_LOW, 16'h0000, "tx gated");
		rd_chk(`ADDR_IDLE_ERR, 16'h0000, "err gated");
		wr_reg(`ADDR_CTRL, 16'h0003);
		rd_chk(`ADDR_CTRL, 16'h0003, "ctrl on");
		$display("test count enable done");
	endtask
	task automatic t_rst();
		@(posedge mclk) pk <= 1'b1;
		@(posedge mclk) pk <= 1'b0;
		sym(0, 1);
		sym(0, 0);
		repeat (6) @(posedge mclk);
		rd_chk(`ADDR_TX_LOW, 16'h0001, "low before reset");
		@(posedge mclk) rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rd_chk(`ADDR_IDLE_ERR, `COUNT16_RESET, "idle after reset");
		rd_chk(`ADDR_TX_LOW, `COUNT16_RESET, "low after reset");
		$display("test mid-run reset done");
	endtask
	task automatic t_idle();
		sym(0, 0);
		sym(0, 1);
		sym(0, 1);
		sym(0, 0);
		sym(1, 1);
		sym(1, 0);
		sym(0, 1);
		sym(0, 0);
		repeat (8) @(posedge mclk);
		rd_chk(`ADDR_IDLE_ERR, 16'h0002, "idle count");
		rd_chk(`ADDR_IDLE_ERR, 16'h0000, "idle cleared");
		$display("test idle error done");
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset();
		t_tx();
		t_burst();
		t_ctrl();
		t_idle();
		t_rst();
		finish_test();
	end
endmodule
